// File: inc/asp_map.svh
// constants of the sequencer serial port: field positions, resets, edge counts
// Function
// RQ1: sixteen-bit write-only channel list shifted from input
// RQ2: list loads only right after walk0 list1 write
// RQ3: list bit 15 is channel 0, bit 0 channel 15
// RQ4: list mode steps upward through enabled channels, wrapping
// RQ5: all-zero list selects channel 15 alone
// RQ6: write with walk0 list0 returns to direct mode
// RQ7: direct mode converts channel of preceding write
// RQ8: walk1 list1 steps consecutive channels without writes
// RQ9: counter runs from 0 up to channel field
// RQ10: walk1 list0 write keeps running sequence intact
// RQ11: select fall holds sampler, drives output, starts conversion
// RQ12: track at edge 14, list frames hold until rise
// RQ13: output floats at edge 16 when weak drive off
// RQ14: frame is channel number then twelve result bits
// RQ15: channel msb at select fall, rest on falls
// RQ16: write bit set loads control over 13 edges
// RQ17: write bit clear leaves control untouched
// RQ18: list load shifts 16 bits, commits on rise
// RQ19: host gives 17 clocks when enabling channel 15
// RQ20: weak drive keeps next channel msb driven weakly
// RQ21: host captures msb on first falling edge
// RQ22: both power bits high keep device powered
// RQ23: reset selects auto shutdown until first select fall
// RQ24: auto shutdown powers down after edge 14
// RQ25: host discards the dummy conversion after wake-up; the bench checks it like any other frame
`ifndef ASP_MAP_SVH
`define ASP_MAP_SVH
`define ASP_CTL_WRITE 12
`define ASP_CTL_WALK 11
`define ASP_CTL_LIST 10
`define ASP_CTL_CHAN_HI 9
`define ASP_CTL_CHAN_LO 6
`define ASP_CTL_PM_HI 5
`define ASP_CTL_PM_LO 4
`define ASP_CTL_WEAK 3
`define ASP_CTL_AUX_HI 2
`define ASP_CTL_RESET 13'h0000
`define ASP_LIST_RESET 16'h0000
`define ASP_LIST_ZERO_SEL 16'h0001
`define ASP_PIN_RESET 3'h6
`define ASP_EDGE_ADDR_END 5'h02
`define ASP_EDGE_CTRL 5'h0C
`define ASP_EDGE_TRACK 5'h0D
`define ASP_EDGE_LAST 5'h0F
`define ASP_EDGE_SAT 5'h11
`define ASP_LIST_BITS 5'h10
`endif

// File: inc/asp_pkg.sv
// types of the sequencer serial port
package asp_pkg;
  typedef enum logic [1:0] {ASP_DIRECT, ASP_LIST, ASP_COUNT} asp_mode_t;
endpackage : asp_pkg

// File: logic/asp_buf2.sv
// two-entry result buffer between converter core and output shifter
`timescale 1ns/10ps
module asp_buf2
  import asp_pkg::*;
(
  input wire logic clk, // core clock
  input wire logic rst, // synchronous reset
  input wire logic [11:0] in_data, // word from converter
  input wire logic in_valid, // word offered
  output logic in_ready, // room for a word
  output logic [11:0] out_data, // oldest word
  output logic out_valid, // a word is held
  input wire logic out_ready // word taken
);
  logic [11:0] mem_ff [2];
  logic wr_ff;
  logic rd_ff;
  logic [1:0] cnt_ff;
  logic rdy_ff;
  wire do_wr = in_valid & in_ready;
  wire do_rd = out_valid & out_ready;
  wire [1:0] nxt_cnt = cnt_ff + {1'b0, do_wr} - {1'b0, do_rd};

  // registered so the ready port leaves the block from a flop
  assign in_ready = rdy_ff;
  assign out_valid = |cnt_ff;
  assign out_data = mem_ff[rd_ff];

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_ff <= 1'b0;
      rd_ff <= 1'b0;
      cnt_ff <= 2'h0;
      rdy_ff <= 1'b1;
    end
    else
    begin
      wr_ff <= wr_ff ^ do_wr;
      rd_ff <= rd_ff ^ do_rd;
      cnt_ff <= nxt_cnt;
      rdy_ff <= ~nxt_cnt[1];
    end
  end

  always_ff @(posedge clk)
  begin
    if (do_wr)
      mem_ff[wr_ff] <= in_data;
  end
endmodule : asp_buf2

// File: logic/asp_serial_ctrl.sv
// serial port, channel sequencer and power control of the converter
`timescale 1ns/10ps
`include "asp_map.svh"
module asp_serial_ctrl
  import asp_pkg::*;
(
  input wire logic CORE_CLK, // 50 MHz core clock
  input wire logic RST, // synchronous reset, high
  input wire logic CHIP_SELECT_N, // frame select pin, low active
  input wire logic SCLK, // serial clock pin
  input wire logic SDI, // serial data in pin
  output logic DOUT_O, // data out level
  output logic DOUT_OE, // data out driven
  output logic DOUT_WEAK, // drive is weak only
  output logic HOLD, // sampler in hold
  output logic POWER_UP, // analog core powered
  output logic CONV_START, // start conversion pulse
  output logic [3:0] CONV_CHAN, // channel being converted
  output logic [2:0] CTRL_AUX, // range, coding, input type bits
  input wire logic [11:0] RES_DATA, // converter result
  input wire logic RES_VALID, // result offered
  output logic RES_READY // result buffer has room
);
  logic [2:0] s1_ff;
  logic [2:0] s2_ff;
  logic [2:0] s3_ff;
  logic [4:0] edge_ff;
  logic [15:0] in_sh_ff;
  logic [12:0] ctrl_ff;
  logic [15:0] list_ff;
  logic list_pend_ff;
  logic list_frame_ff;
  asp_mode_t mode_ff;
  logic [3:0] ptr_ff;
  logic [3:0] ctr_ff;
  logic [11:0] data_ff;
  logic dout_ff;
  logic oe_ff;
  logic weak_ff;
  logic hold_ff;
  logic pwr_ff;
  logic start_ff;
  logic [3:0] chan_ff;
  logic commit_d_ff;
  logic [11:0] buf_data;
  logic buf_valid;
  logic buf_in_ready;

  // chooses the first enabled channel at or above start, wrapping
  function automatic logic [3:0] asp_next_chan(input logic [15:0] en, input logic [3:0] start);
    logic [3:0] res;
    logic found;
    res = 4'hF;
    found = 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      if (!found && en[4'(start + 4'(i))])
      begin
        res = 4'(start + 4'(i));
        found = 1'b1;
      end
    end
    return res;
  endfunction : asp_next_chan

  // pins pass two flops; edges compare second and third stage only
  wire cs_n_s = s2_ff[2];
  wire cs_fall = s3_ff[2] & ~cs_n_s;
  wire cs_rise = ~s3_ff[2] & cs_n_s;
  wire sck_fall = s3_ff[1] & ~s2_ff[1] & ~cs_n_s & ~cs_fall;
  wire sdi_s = s2_ff[0];

  wire [3:0] chan_field = ctrl_ff[`ASP_CTL_CHAN_HI:`ASP_CTL_CHAN_LO];
  wire pm_hi = ctrl_ff[`ASP_CTL_PM_HI];
  wire weak_bit = ctrl_ff[`ASP_CTL_WEAK];

  wire [15:0] eff_list = (list_ff == 16'h0000) ? `ASP_LIST_ZERO_SEL : list_ff; // RQ5
  wire [15:0] chan_en;
  genvar g;
  generate
    for (g = 0; g < 16; g++)
    begin : g_map
      assign chan_en[g] = eff_list[15 - g]; // RQ3
    end
  endgenerate

  wire [3:0] list_chan = asp_next_chan(chan_en, ptr_ff); // RQ4
  wire [3:0] next_chan = (mode_ff == ASP_LIST) ? list_chan :
                         (mode_ff == ASP_COUNT) ? ctr_ff : chan_field; // RQ7 RQ8

  wire edge_ctrl = sck_fall & (edge_ff == `ASP_EDGE_CTRL);
  wire edge_track = sck_fall & (edge_ff == `ASP_EDGE_TRACK);
  wire edge_last = sck_fall & (edge_ff == `ASP_EDGE_LAST);
  wire edge_data = sck_fall & (edge_ff == `ASP_EDGE_ADDR_END);
  wire [12:0] ctrl_word = {in_sh_ff[11:0], sdi_s};
  wire ctrl_wr = edge_ctrl & ~list_frame_ff & ctrl_word[`ASP_CTL_WRITE]; // RQ16 RQ17
  wire wr_walk = ctrl_word[`ASP_CTL_WALK];
  wire wr_list = ctrl_word[`ASP_CTL_LIST];
  wire list_commit = cs_rise & list_frame_ff & (edge_ff >= `ASP_LIST_BITS); // RQ18
  wire [15:0] frame_word = {chan_ff, data_ff}; // RQ14
  wire [3:0] out_idx = 4'hE - edge_ff[3:0];
  wire pop = edge_data & buf_valid;

  asp_buf2 u_buf (
    .clk(CORE_CLK),
    .rst(RST),
    .in_data(RES_DATA),
    .in_valid(RES_VALID),
    .in_ready(buf_in_ready),
    .out_data(buf_data),
    .out_valid(buf_valid),
    .out_ready(pop)
  );

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      s1_ff <= `ASP_PIN_RESET;
      s2_ff <= `ASP_PIN_RESET;
      s3_ff <= `ASP_PIN_RESET;
    end
    else
    begin
      s1_ff <= {CHIP_SELECT_N, SCLK, SDI};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // falling-edge count and input shifter
  always_ff @(posedge CORE_CLK)
  begin
    if (RST || cs_fall)
      edge_ff <= 5'h00;
    else if (sck_fall && edge_ff != `ASP_EDGE_SAT)
      edge_ff <= edge_ff + 5'h01;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
      in_sh_ff <= 16'h0000;
    else if (sck_fall && edge_ff <= `ASP_EDGE_LAST)
      in_sh_ff <= {in_sh_ff[14:0], sdi_s}; // RQ1
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
      ctrl_ff <= `ASP_CTL_RESET; // RQ23
    else if (ctrl_wr)
      ctrl_ff <= ctrl_word; // RQ16
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
      list_ff <= `ASP_LIST_RESET;
    else if (list_commit)
      list_ff <= in_sh_ff; // RQ18
  end

  // list load is armed only by the write just before it
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      list_pend_ff <= 1'b0;
      list_frame_ff <= 1'b0;
    end
    else if (cs_fall)
    begin
      list_frame_ff <= list_pend_ff; // RQ2
      list_pend_ff <= 1'b0;
    end
    else if (ctrl_wr)
      list_pend_ff <= ~wr_walk & wr_list; // RQ2
    else if (cs_rise)
      list_frame_ff <= 1'b0;
  end

  // sequence state; a walk1 list0 write leaves it untouched
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      mode_ff <= ASP_DIRECT;
      ptr_ff <= 4'h0;
      ctr_ff <= 4'h0;
    end
    else if (list_commit)
    begin
      mode_ff <= ASP_LIST;
      ptr_ff <= 4'h0;
    end
    else if (ctrl_wr && !(wr_walk && !wr_list)) // RQ10
    begin
      mode_ff <= (wr_walk && wr_list) ? ASP_COUNT : ASP_DIRECT; // RQ8 RQ6
      ctr_ff <= 4'h0;
    end
    else if (cs_fall)
    begin
      unique case (mode_ff)
        ASP_LIST: ptr_ff <= list_chan + 4'h1; // RQ4
        ASP_COUNT: ctr_ff <= (ctr_ff == chan_field) ? 4'h0 : ctr_ff + 4'h1; // RQ9
        ASP_DIRECT: ptr_ff <= ptr_ff;
      endcase
    end
  end

  // result fetched before the first data bit goes out; empty gives zeros
  always_ff @(posedge CORE_CLK)
  begin
    if (RST || cs_fall)
      data_ff <= 12'h000;
    else if (edge_data)
      data_ff <= buf_valid ? buf_data : 12'h000;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      chan_ff <= 4'h0;
      start_ff <= 1'b0;
    end
    else
    begin
      start_ff <= cs_fall; // RQ11
      if (cs_fall)
        chan_ff <= next_chan;
    end
  end

  // one cycle after a list commit the new first channel is known
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
      commit_d_ff <= 1'b0;
    else
      commit_d_ff <= list_commit;
  end

  // data out: strong from select fall, floated or weak after edge 16
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      dout_ff <= 1'b0;
      oe_ff <= 1'b0;
      weak_ff <= 1'b0;
    end
    else if (cs_fall)
    begin
      dout_ff <= next_chan[3]; // RQ15
      oe_ff <= 1'b1; // RQ11
      weak_ff <= 1'b0;
    end
    else if (edge_last || (cs_rise && edge_ff <= `ASP_EDGE_LAST && !weak_ff))
    begin
      dout_ff <= next_chan[3]; // RQ20
      oe_ff <= weak_bit; // RQ13
      weak_ff <= weak_bit; // RQ20
    end
    else if (commit_d_ff && weak_ff)
      dout_ff <= next_chan[3]; // RQ20
    else if (sck_fall && edge_ff < `ASP_EDGE_LAST)
      dout_ff <= frame_word[out_idx]; // RQ14 RQ15
  end

  // sampler and power; reset leaves the core asleep in hold
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      hold_ff <= 1'b1;
      pwr_ff <= 1'b0; // RQ23
    end
    else if (cs_fall)
    begin
      hold_ff <= 1'b1; // RQ11
      pwr_ff <= 1'b1; // RQ24
    end
    else if (edge_track && !list_frame_ff)
    begin
      hold_ff <= ~pm_hi; // RQ12 RQ24
      pwr_ff <= pm_hi; // RQ22 RQ24
    end
    else if (edge_track)
      pwr_ff <= pm_hi;
    else if (list_commit)
      hold_ff <= ~pwr_ff; // RQ12 RQ18
  end

  assign DOUT_O = dout_ff;
  assign DOUT_OE = oe_ff;
  assign DOUT_WEAK = weak_ff;
  assign HOLD = hold_ff;
  assign POWER_UP = pwr_ff;
  assign CONV_START = start_ff;
  assign CONV_CHAN = chan_ff;
  assign CTRL_AUX = ctrl_ff[`ASP_CTL_AUX_HI:0];
  assign RES_READY = buf_in_ready;

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);

  chk_hold_at_fall: assert property (cs_fall |=> hold_ff && oe_ff && start_ff) // RQ11
    else $error("select fall did not hold and drive");
  chk_msb_first: assert property (cs_fall |=> dout_ff == chan_ff[3] && !weak_ff) // RQ15
    else $error("channel msb not driven at select fall");
  chk_track_edge: assert property (edge_track && !list_frame_ff && pm_hi |=> !hold_ff) // RQ12
    else $error("sampler not tracking after edge 14");
  chk_list_hold: assert property (edge_track && list_frame_ff |=> hold_ff) // RQ12
    else $error("sampler left hold during list load");
  chk_float_edge: assert property (edge_last && !weak_bit |=> !oe_ff) // RQ13
    else $error("data out not floated at edge 16");
  chk_weak_edge: assert property (edge_last && weak_bit |=> oe_ff && weak_ff) // RQ20
    else $error("weak drive not kept after edge 16");
  chk_shutdown: assert property (edge_track && !pm_hi |=> !pwr_ff) // RQ24
    else $error("no shutdown after edge 14");
  chk_wake: assert property (cs_fall |=> pwr_ff) // RQ23
    else $error("no wake at select fall");
  chk_ctrl_keep: assert property (edge_ctrl && !ctrl_word[`ASP_CTL_WRITE] |=> $stable(ctrl_ff)) // RQ17
    else $error("control changed without write bit");
  chk_count_wrap: assert property (cs_fall && mode_ff == ASP_COUNT && ctr_ff == chan_field // RQ9
                                   |=> ctr_ff == 4'h0)
    else $error("counter did not wrap at channel field");
  chk_direct_chan: assert property (cs_fall && mode_ff == ASP_DIRECT // RQ7
                                    |=> chan_ff == $past(chan_field))
    else $error("direct mode used wrong channel");
  chk_list_load: assert property (list_commit |=> list_ff == $past(in_sh_ff) && mode_ff == ASP_LIST) // RQ18
    else $error("channel list not committed");
  chk_list_pick: assert property (cs_fall && mode_ff == ASP_LIST |=> chan_en[chan_ff]) // RQ4
    else $error("list mode picked disabled channel");
  chk_weak_list: assert property (commit_d_ff && weak_ff && !cs_fall // RQ20
                                  |=> dout_ff == list_chan[3])
    else $error("weak msb not moved to first list channel");

  cov_list_load: cover property (list_commit);
  cov_count_wrap: cover property (cs_fall && mode_ff == ASP_COUNT && ctr_ff == chan_field);
  cov_weak_hold: cover property (edge_last && weak_bit);
  cov_shutdown: cover property (edge_track && !pm_hi);
  cov_weak_list: cover property (commit_d_ff && weak_ff);
endmodule : asp_serial_ctrl

// File: verification/asp_host.sv
// serial master model: select, serial clock and data in
`timescale 1ns/10ps
module asp_host (
  input wire logic dout_o, // data out level
  input wire logic dout_oe, // data out driven
  output logic cs_n, // frame select, low active
  output logic sclk, // serial clock
  output logic sdi // serial data in
);
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b1;
    sdi = 1'b0;
  end
  // clock stands high between frames; each phase 4 core cycles
  task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
    cs_n = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      sdi = (i < 16) ? tx[15 - i] : ~sdi;
      #80;
      // a floating line reads as the inverse, never as a lucky match
      if (i < 16)
        rx[15 - i] = dout_oe ? dout_o : ~dout_o;
      sclk = 1'b0;
      #80;
      sclk = 1'b1;
    end
    #80;
    cs_n = 1'b1;
    sdi = ~sdi;
    #160;
  endtask : xfer
endmodule : asp_host

// File: verification/adc_sequencer_serial_port_bench.sv
// self-checking bench of the sequencer serial port
`timescale 1ns/10ps
module adc_sequencer_serial_port_bench
  import asp_pkg::*;
;
  logic CORE_CLK = 1'b0;
  logic RST = 1'b1;
  logic [11:0] RES_DATA = 12'h000;
  logic RES_VALID = 1'b0;
  wire cs_n, sclk, sdi, dout_o, dout_oe, dout_weak, hold, power_up, conv_start, res_ready;
  wire [3:0] conv_chan;
  wire [2:0] ctrl_aux;
  int n_mismatch = 0;
  int samples_checked = 0;
  int n_start = 0;
  int mode = 0;
  int ptr = 0;
  int cnt = 0;
  int n_dummy = 0;
  int exp_dummy = 0;
  int ch;
  logic [31:0] seed = 32'h3E4CC050;
  logic [12:0] ctl = 13'h0000;
  logic [15:0] lst = 16'h0001;
  logic ld = 1'b0;
  logic [11:0] resq[$];
  // 17'h00000 marks a random frame without write; bit 16 asks for 17 clocks
  logic [16:0] plan [24] = '{17'h08BA8, 17'h00000, 17'h0B7D0, 17'h14A01, 17'h00000,
    17'h00000, 17'h00000, 17'h00000, 17'h00000, 17'h0C7B8, 17'h00000, 17'h0E400,
    17'h00000, 17'h00000, 17'h00000, 17'h00000, 17'h0B388, 17'h10000, 17'h00000,
    17'h00000, 17'h099E0, 17'h00000, 17'h00000, 17'h00000};

  asp_serial_ctrl uut (.CORE_CLK(CORE_CLK), .RST(RST), .CHIP_SELECT_N(cs_n), .SCLK(sclk),
    .SDI(sdi), .DOUT_O(dout_o), .DOUT_OE(dout_oe), .DOUT_WEAK(dout_weak), .HOLD(hold),
    .POWER_UP(power_up), .CONV_START(conv_start), .CONV_CHAN(conv_chan),
    .CTRL_AUX(ctrl_aux), .RES_DATA(RES_DATA), .RES_VALID(RES_VALID), .RES_READY(res_ready));
  asp_host host (.dout_o(dout_o), .dout_oe(dout_oe), .cs_n(cs_n), .sclk(sclk), .sdi(sdi));

  always #10 CORE_CLK = ~CORE_CLK;
  always @(posedge CORE_CLK)
    if (conv_start === 1'b1)
      n_start <= n_start + 1;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic int pick();
    int c;
    if (mode == 2)
      return cnt;
    if (mode == 0)
      return int'(ctl[9:6]);
    for (int k = 0; k < 16; k++)
    begin
      c = (ptr + k) % 16;
      if (lst[15 - c])
        return c;
    end
    return 15;
  endfunction : pick

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // converter side offers a word and holds it until taken or for at most 20 cycles
  task automatic push();
    int w;
    @(negedge CORE_CLK);
    seed = lfsr(seed);
    RES_DATA = seed[11:0];
    RES_VALID = 1'b1;
    for (w = 0; w < 20 && res_ready !== 1'b1; w++)
      @(negedge CORE_CLK);
    @(posedge CORE_CLK);
    resq.push_back(RES_DATA);
    @(negedge CORE_CLK);
    RES_VALID = 1'b0;
  endtask : push

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report

  initial
  begin : main
    logic [15:0] tx, rx;
    logic [3:0] exp_ch;
    logic [11:0] exp_res;
    repeat (4) @(posedge CORE_CLK);
    @(negedge CORE_CLK);
    RST = 1'b0;
    @(negedge CORE_CLK);
    chk(power_up, 16'h0000);
    chk(hold, 16'h0001);
    chk(dout_oe, 16'h0000);
    push();
    push();
    chk(res_ready, 16'h0000);
    $display("test reset and buffer fill done");
    for (int f = 0; f < 24; f++)
    begin
      seed = lfsr(seed);
      tx = (plan[f] == 17'h00000) ? {1'b0, seed[14:0]} : plan[f][15:0];
      ch = pick();
      exp_ch = ch[3:0];
      exp_res = (resq.size() > 0) ? resq.pop_front() : 12'h000;
      n_start = 0;
      // a frame that starts from shutdown is the wake-up dummy; the bench still checks its result like any other
      if (!ctl[5])
        exp_dummy++;
      if (power_up !== 1'b1)
        n_dummy++;
      host.xfer(tx, plan[f][16] ? 17 : 16, rx);
      if (mode == 1)
        ptr = (ch + 1) % 16;
      if (mode == 2)
        cnt = (cnt == int'(ctl[9:6])) ? 0 : cnt + 1;
      if (ld)
      begin
        lst = (tx == 16'h0000) ? 16'h0001 : tx;
        mode = 1;
        ptr = 0;
        ld = 1'b0;
      end
      else if (tx[15])
      begin
        ctl = tx[15:3];
        case (tx[14:13])
          2'b00: mode = 0;
          2'b01:
          begin
            mode = 0;
            ld = 1'b1;
          end
          2'b11:
          begin
            mode = 2;
            cnt = 0;
          end
          default: ;
        endcase
      end
      repeat (2) @(negedge CORE_CLK);
      chk(rx, {exp_ch, exp_res});
      chk(conv_chan, exp_ch);
      chk(16'(n_start), 16'h0001);
      chk(ctrl_aux, ctl[2:0]);
      chk(power_up, ctl[5]);
      chk(hold, !ctl[5]);
      chk(dout_oe, ctl[3]);
      chk(dout_weak, ctl[3]);
      if (ctl[3])
        chk(dout_o, 16'(pick() >> 3));
      if (f < 21)
        push();
      $display("test frame %0d done", f);
    end
    chk(16'(n_dummy), 16'(exp_dummy));
    final_report();
  end

  initial
  begin
    #500000;
    n_mismatch++;
    final_report();
  end
endmodule : adc_sequencer_serial_port_bench
